// *** pkg/uaved_pkg.sv ***
// Package of field layouts, opcodes and register offsets for the export decoder.
package uaved_pkg;
    // ----------------------------------------------------------------
    // Low instruction word fields.
    // ----------------------------------------------------------------
    localparam int VIEW_SEL_LSB = 0;   // View selector, 4 bits.
    localparam int VIEW_OP_LSB  = 4;   // View opcode, 6 bits.
    localparam int IDX_MODE_LSB = 11;  // View index mode, 2 bits.
    localparam int TYPE_LSB     = 13;  // Export type, 2 bits.
    localparam int SRC_REG_LSB  = 15;  // Source register number, 7 bits.
    localparam int SRC_REL_BIT  = 22;  // Source register loop-relative flag.
    localparam int COORD_LSB    = 23;  // Coordinate register number, 7 bits.
    localparam int ELEM_LSB     = 30;  // Element size minus one, 2 bits.
    // ----------------------------------------------------------------
    // High instruction word fields.
    // ----------------------------------------------------------------
    localparam int ARR_LSB      = 0;   // Array size, 12 bits.
    localparam int MASK_LSB     = 12;  // Component mask, 4 bits.
    localparam int BURST_LSB    = 16;  // Burst count minus one, 4 bits.
    localparam int VPM_BIT      = 20;  // Valid pixel mode.
    localparam int FLOW_LSB     = 22;  // Flow opcode, 8 bits.
    localparam int MARK_BIT     = 30;  // Acknowledge mark.
    localparam int BARRIER_BIT  = 31;  // Synchronisation barrier.
    // ----------------------------------------------------------------
    // Opcodes.
    // ----------------------------------------------------------------
    localparam logic [5:0] OP_RTN_OFS  = 6'h20;  // Offset of returning forms.
    localparam logic [7:0] FLOW_STREAM = 8'h40;  // First stream/buffer write.
    localparam logic [7:0] FLOW_SCRATCH = 8'h50; // Scratch buffer write.
    localparam logic [1:0] ELEM_BAD    = 2'h3;   // Unsupported element size.
    localparam logic [1:0] IDX_BAD     = 2'h3;   // Invalid index mode.
    typedef enum logic [5:0] {
        op_nop            = 6'h00,
        op_store_formatted = 6'h01,
        op_compare_swap   = 6'h04,
        op_add            = 6'h07,
        op_sub            = 6'h08,
        op_rsub           = 6'h09,
        op_min_signed     = 6'h0A,
        op_min_unsigned   = 6'h0B,
        op_max_signed     = 6'h0C,
        op_max_unsigned   = 6'h0D,
        op_and            = 6'h0E,
        op_or             = 6'h0F,
        op_xor            = 6'h10,
        op_wrap_increment = 6'h12,
        op_wrap_decrement = 6'h13,
        op_store_dword    = 6'h14,
        op_store_short    = 6'h15,
        op_store_byte     = 6'h16,
        op_flush_ack      = 6'h20,
        op_swap_returning = 6'h22
    } uaved_op_t;
    // ----------------------------------------------------------------
    // Register byte offsets.
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_INSTR_LO = 8'h00;  // Low instruction word.
    localparam logic [7:0] REG_INSTR_HI = 8'h04;  // High word; write issues.
    localparam logic [7:0] REG_INDEX0   = 8'h08;  // Index register 0.
    localparam logic [7:0] REG_INDEX1   = 8'h0C;  // Index register 1.
    localparam logic [7:0] REG_LOOP     = 8'h10;  // Loop index value.
    localparam logic [7:0] REG_DEST     = 8'h14;  // Destination dword.
    localparam logic [7:0] REG_SRC      = 8'h18;  // Source dword (X).
    localparam logic [7:0] REG_CMP      = 8'h1C;  // Compare dword (W).
    localparam logic [7:0] REG_COORD    = 8'h20;  // Coordinate X value.
    localparam logic [7:0] REG_THREAD   = 8'h24;  // Bit0 active, bit1 valid.
    localparam logic [7:0] REG_RETURN   = 8'h28;  // Returned dword.
    localparam logic [7:0] REG_DEC0     = 8'h2C;  // Decoded view fields.
    localparam logic [7:0] REG_DEC1     = 8'h30;  // Decoded addressing.
    localparam logic [7:0] REG_DEC2     = 8'h34;  // Decoded buffer fields.
    localparam logic [7:0] REG_STATUS   = 8'h38;  // Status flags.
    localparam logic [7:0] REG_DONE     = 8'h3C;  // Write: one prior completes.
endpackage

// *** rtl/uaved_decode.sv ***
// Export instruction pair decoder with atomic view operation unit and APB access.
`timescale 1ns/10ps

// Summary of operation
// - Low four bits select target view.
// - Bits 9:4 opcode; 1 is formatted store.
// - Opcode 4 swaps only when compare equals.
// - Opcodes 7-9 wrap add, sub, reverse sub.
// - Opcodes 10-13 signed/unsigned min and max.
// - Opcodes 14-16 bitwise AND, OR, XOR.
// - Opcode 18 wrapping unsigned increment.
// - Opcode 19 wrapping unsigned decrement.
// - Opcode 34 swaps and returns dword.
// - Opcodes 36, 39-48, 50-51 return after operating.
// - Index mode adds index register to view.
// - Type selects indexed and acknowledged writes.
// - Source register holds data or X/Y/W.
// - Bit 22 adds loop index to register.
// - Coordinate register scaled by element size.
// - Element size scales; value 3 unsupported.
// - Array size; low byte is stride.
// - Component mask gates written components.
// - Burst count is values minus one.
// - Valid pixel mode bit is only reported in status.
// - High opcode decodes stream, buffer, scratch.
// - Mark flags write for next acknowledgement.
// - Barrier holds until the saturating count of prior instructions drains to zero.
module uaved_decode import uaved_pkg::*; #(
    parameter int PEND_W = 4  // Width of the outstanding-instruction counter.
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             export_issue,
    output logic             export_hold
);
    // ----------------------------------------------------------------
    // Elaboration check.
    // ----------------------------------------------------------------
    if (PEND_W < 1 || PEND_W > 16) begin : g_chk
        $error("PEND_W must lie between 1 and 16.");
    end

    // ----------------------------------------------------------------
    // Storage.
    // ----------------------------------------------------------------
    logic [31:0]       lo_q, hi_q;        // Instruction pair.
    logic [31:0]       idx0_q, idx1_q;    // Index registers.
    logic [31:0]       loop_q;            // Loop index value.
    logic [31:0]       dst_q, src_q;      // Destination and source dwords.
    logic [31:0]       cmp_q, coord_q;    // Compare and coordinate dwords.
    logic [1:0]        thread_q;          // Active and pixel-valid bits.
    logic [31:0]       ret_q;             // Returned dword.
    logic [31:0]       dec0_q, dec1_q;    // Captured decode results.
    logic [31:0]       dec2_q, stat_q;    // Captured decode results.
    logic [PEND_W-1:0] pend_q;            // Outstanding prior instructions.
    logic              wait_q;            // Instruction waiting to run.
    logic [31:0]       prdata_q;          // Read data register.
    logic              pready_q;          // Ready register.
    logic              pslverr_q;         // Error register.
    logic              issue_q;           // Issue pulse register.

    // Bus strobes: a write is taken at the access edge only.
    logic wr_en, setup, issue_req, run;
    assign setup     = psel && !penable;
    assign wr_en     = psel && penable && pready_q && pwrite;
    assign issue_req = wr_en && (paddr == REG_INSTR_HI) && !wait_q;

    // ----------------------------------------------------------------
    // Field extraction.
    // ----------------------------------------------------------------
    logic [3:0]  view_selector;
    logic [5:0]  view_opcode;
    logic [1:0]  view_index_mode, exp_type, elem;
    logic [6:0]  source_reg_num, coord_reg_num;
    logic        source_reg_relative;
    logic [11:0] arr_size;
    logic [3:0]  comp_mask, burst;
    logic [7:0]  flow_opcode;
    assign view_selector       = lo_q[VIEW_SEL_LSB +: 4];
    assign view_opcode         = lo_q[VIEW_OP_LSB +: 6];
    assign view_index_mode     = lo_q[IDX_MODE_LSB +: 2];
    assign exp_type            = lo_q[TYPE_LSB +: 2];
    assign source_reg_num      = lo_q[SRC_REG_LSB +: 7];
    assign source_reg_relative = lo_q[SRC_REL_BIT];
    assign coord_reg_num       = lo_q[COORD_LSB +: 7];
    assign elem                = lo_q[ELEM_LSB +: 2];
    assign arr_size            = hi_q[ARR_LSB +: 12];
    assign comp_mask           = hi_q[MASK_LSB +: 4];
    assign burst               = hi_q[BURST_LSB +: 4];
    assign flow_opcode         = hi_q[FLOW_LSB +: 8];

    // ----------------------------------------------------------------
    // Address and count decode.
    // ----------------------------------------------------------------
    logic [3:0]  view_eff;      // Effective view after indexing.
    logic [6:0]  src_eff;       // Effective source register.
    logic [31:0] coord_scaled;  // Coordinate times element dwords.
    logic [6:0]  burst_total;   // Dwords moved by a memory burst.
    logic [8:0]  stride;        // Cacheless burst stride in dwords.
    logic        idx_bad, elem_bad;
    always_comb begin
        unique case (view_index_mode)
            2'h1:    view_eff = view_selector + idx0_q[3:0];
            2'h2:    view_eff = view_selector + idx1_q[3:0];
            default: view_eff = view_selector;
        endcase
    end
    assign idx_bad  = (view_index_mode == IDX_BAD);
    assign elem_bad = (elem == ELEM_BAD);
    assign src_eff  = source_reg_relative ? 7'(source_reg_num + loop_q[6:0])
                                          : source_reg_num;
    assign coord_scaled = 32'(coord_q * ({30'h0, elem} + 32'h1));
    // burst count is values minus one
    assign burst_total  = 7'(({3'h0, burst} + 7'h1) * ({5'h0, elem} + 7'h1));
    // low byte gives stride of 1..256
    assign stride = {1'b0, arr_size[7:0]} + 9'h1;

    // ----------------------------------------------------------------
    // Flow opcode classification.
    // ----------------------------------------------------------------
    logic       is_stream, is_scratch;
    logic [7:0] flow_rel;
    assign flow_rel = flow_opcode - FLOW_STREAM;
    assign is_stream  = (flow_opcode >= FLOW_STREAM) && (flow_opcode < FLOW_SCRATCH);
    assign is_scratch = (flow_opcode == FLOW_SCRATCH);

    // ----------------------------------------------------------------
    // Atomic operation unit.
    // ----------------------------------------------------------------
    logic [5:0]  base_op;   // Opcode with returning offset removed.
    logic        rtn;       // Operation returns a dword.
    logic        legal;     // Opcode is defined.
    logic        modifies;  // Opcode writes the destination.
    logic [31:0] res;       // New destination value.
    assign rtn     = view_opcode >= OP_RTN_OFS;
    assign base_op = rtn ? view_opcode - OP_RTN_OFS : view_opcode;

    always_comb begin
        legal    = 1'b1;
        modifies = 1'b1;
        res      = dst_q;
        if (rtn) begin
            // returning forms cover 0, 2, 4, 7..16 and 18..19
            unique case (base_op)
                6'h00, 6'h02: legal = 1'b1;
                6'h04, 6'h07, 6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C,
                6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h12, 6'h13: legal = 1'b1;
                default: legal = 1'b0;
            endcase
        end else begin
            legal = !(base_op inside {6'h02, 6'h03, 6'h05, 6'h06, 6'h11}) &&
                    (base_op <= 6'h16);
        end
        unique case (base_op)
            6'h04: res = (cmp_q == dst_q) ? src_q : dst_q;
            6'h07: res = src_q + dst_q;
            6'h08: res = dst_q - src_q;
            6'h09: res = src_q - dst_q;
            6'h0A: res = ($signed(src_q) < $signed(dst_q)) ? src_q : dst_q;
            6'h0B: res = (src_q < dst_q) ? src_q : dst_q;
            6'h0C: res = ($signed(src_q) > $signed(dst_q)) ? src_q : dst_q;
            6'h0D: res = (src_q > dst_q) ? src_q : dst_q;
            6'h0E: res = dst_q & src_q;
            6'h0F: res = dst_q | src_q;
            6'h10: res = dst_q ^ src_q;
            6'h12: res = (dst_q >= src_q) ? 32'h0 : dst_q + 32'h1;
            6'h13: res = ((dst_q == 32'h0) || (dst_q > src_q)) ? src_q : dst_q - 32'h1;
            6'h01: res = src_q;
            // swap with return, no denormal flush
            6'h02: res = src_q;
            6'h14: res = src_q;
            6'h15: res = {dst_q[31:16], src_q[15:0]};
            6'h16: res = {dst_q[31:8], src_q[7:0]};
            default: modifies = 1'b0;
        endcase
        if (base_op == 6'h02 && !rtn) begin
            modifies = 1'b0;
        end
        if (base_op == 6'h00) begin
            modifies = 1'b0;
        end
    end

    // Write permitted: legal, supported fields, active lane, X enabled.
    logic do_write, suppressed;
    // memory exports gate on active mask only
    assign suppressed = !thread_q[0];
    // X is the component mask LSB
    assign do_write = legal && !idx_bad && !elem_bad && !suppressed &&
                      modifies && comp_mask[0];

    // ----------------------------------------------------------------
    // Barrier and issue sequencing.
    // ----------------------------------------------------------------
    logic done_wr;
    assign done_wr = wr_en && (paddr == REG_DONE);
    // barrier holds until no prior pending
    assign run = wait_q && (!hi_q[BARRIER_BIT] || pend_q == '0);

    // Waiting flag: set by a high-word write, cleared when it runs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q <= 1'b0;
        end else if (issue_req) begin
            wait_q <= 1'b1;
        end else if (run) begin
            wait_q <= 1'b0;
        end
    end

    // Outstanding counter: an issue and a completion together cancel.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= '0;
        end else if (run && !(done_wr && pend_q != '0)) begin
            if (pend_q != '1) begin
                pend_q <= pend_q + 1'b1;
            end
        end else if (!run && done_wr && pend_q != '0) begin
            pend_q <= pend_q - 1'b1;
        end
    end

    // Issue pulse output register; the hold level output is the waiting flag.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            issue_q <= 1'b0;
        end else begin
            issue_q <= run;
        end
    end

    // ----------------------------------------------------------------
    // Software-written registers.
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lo_q     <= 32'h0;
            hi_q     <= 32'h0;
            idx0_q   <= 32'h0;
            idx1_q   <= 32'h0;
            loop_q   <= 32'h0;
            src_q    <= 32'h0;
            cmp_q    <= 32'h0;
            coord_q  <= 32'h0;
            thread_q <= 2'h1;
        end else if (wr_en) begin
            unique case (paddr)
                REG_INSTR_LO: lo_q     <= wait_q ? lo_q : pwdata;
                REG_INSTR_HI: hi_q     <= wait_q ? hi_q : pwdata;
                REG_INDEX0:   idx0_q   <= pwdata;
                REG_INDEX1:   idx1_q   <= pwdata;
                REG_LOOP:     loop_q   <= pwdata;
                REG_SRC:      src_q    <= pwdata;
                REG_CMP:      cmp_q    <= pwdata;
                REG_COORD:    coord_q  <= pwdata;
                REG_THREAD:   thread_q <= pwdata[1:0];
                default:      ;
            endcase
        end
    end

    // Destination: execution wins over a same-cycle software write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dst_q <= 32'h0;
            ret_q <= 32'h0;
        end else if (run) begin
            if (do_write) begin
                dst_q <= res;
            end
            // returning forms give back prior value
            if (rtn && legal) begin
                ret_q <= dst_q;
            end
        end else if (wr_en && paddr == REG_DEST) begin
            dst_q <= pwdata;
        end
    end

    // ----------------------------------------------------------------
    // Decode capture at execution.
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dec0_q <= 32'h0;
            dec1_q <= 32'h0;
            dec2_q <= 32'h0;
            stat_q <= 32'h0;
        end else if (run) begin
            dec0_q <= {16'h0, comp_mask, view_opcode, 2'h0, view_eff};
            dec1_q <= {coord_scaled[15:0], 2'h0, burst_total, src_eff};
            dec2_q <= {10'h0, stride[8:0], coord_reg_num, is_scratch, is_stream,
                       flow_rel[3:2], flow_rel[1:0]};
            stat_q <= {20'h0, hi_q[VPM_BIT], suppressed, do_write, rtn,
                       exp_type[0], exp_type[1], hi_q[MARK_BIT] && (is_stream ||
                       is_scratch || exp_type[1]), hi_q[BARRIER_BIT],
                       elem_bad, idx_bad, !legal, 1'b0};
        end
    end

    // ----------------------------------------------------------------
    // APB read path, ready and error, all registered.
    // ----------------------------------------------------------------
    logic [31:0] rd_mux;
    logic        mapped;
    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0;
        unique case (paddr)
            REG_INSTR_LO: rd_mux = lo_q;
            REG_INSTR_HI: rd_mux = hi_q;
            REG_INDEX0:   rd_mux = idx0_q;
            REG_INDEX1:   rd_mux = idx1_q;
            REG_LOOP:     rd_mux = loop_q;
            REG_DEST:     rd_mux = dst_q;
            REG_SRC:      rd_mux = src_q;
            REG_CMP:      rd_mux = cmp_q;
            REG_COORD:    rd_mux = coord_q;
            REG_THREAD:   rd_mux = {30'h0, thread_q};
            REG_RETURN:   rd_mux = ret_q;
            REG_DEC0:     rd_mux = dec0_q;
            REG_DEC1:     rd_mux = dec1_q;
            REG_DEC2:     rd_mux = dec2_q;
            REG_STATUS:   rd_mux = {16'(pend_q), stat_q[15:1], wait_q};
            REG_DONE:     rd_mux = 32'h0;
            default:      mapped = 1'b0;
        endcase
    end

    // Ready rises one cycle after setup, giving one wait-free access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && !mapped;
            if (setup && !pwrite) begin
                prdata_q <= rd_mux;
            end
        end
    end

    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign export_issue = issue_q;
    assign export_hold  = wait_q;
endmodule

// *** test/uaved_decode_assertions.sv ***
// Port-level property checker for the export decoder.
`timescale 1ns/10ps
module uaved_decode_chk import uaved_pkg::*; (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        export_issue,
    input wire logic        export_hold
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Bus setup phase and an accepted issuing write.
    sequence s_setup; psel && !penable; endsequence
    sequence s_issue; psel && penable && pready && pwrite && paddr == REG_INSTR_HI
        && !export_hold; endsequence
    property p_rdy; s_setup |=> pready; endproperty
    property p_rdy_only; pready |-> psel && penable && $past(psel && !penable); endproperty
    property p_err_rdy; pslverr |-> pready; endproperty
    property p_unmap; s_setup and paddr > REG_DONE |=> pslverr; endproperty
    property p_map; s_setup and paddr[1:0] == 2'h0 && paddr <= REG_DONE |=> !pslverr;
    endproperty
    property p_quick; s_issue and !pwdata[BARRIER_BIT] |=> export_hold ##1
        (!export_hold && export_issue); endproperty
    property p_bar; s_issue and pwdata[BARRIER_BIT] |=> export_hold; endproperty
    property p_pulse; export_issue |=> !export_issue; endproperty
    property p_after; export_issue |-> !export_hold && $past(export_hold); endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    a_rdy_only: assert property (p_rdy_only) else $error("stray ready");
    a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
    a_unmap: assert property (p_unmap) else $error("unmapped not refused");
    a_map: assert property (p_map) else $error("mapped refused");
    a_quick: assert property (p_quick) else $error("issue late");
    a_bar: assert property (p_bar) else $error("barrier not held");
    a_pulse: assert property (p_pulse) else $error("issue not a pulse");
    a_after: assert property (p_after) else $error("issue without hold");
endmodule
bind uaved_decode uaved_decode_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .export_issue, .export_hold);

// *** test/uaved_decode_tb_top.sv ***
// Self-checking bench for the export decoder.
`timescale 1ns/10ps
module uaved_decode_tb_top import uaved_pkg::*;;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        export_issue, export_hold;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    int          err_total, n_tests;
    uaved_decode dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .export_issue, .export_hold);
    uaved_seq_model apb_u (.pclk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite,
        .paddr, .pwdata);
    // Compare and count.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb_u.xfer(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb_u.xfer(1'b0, a, 32'h0, r, e);
    endtask
    // Issue a pair and wait for the hold to clear.
    task automatic run(input logic [31:0] lo, input logic [31:0] hi);
        wr(REG_INSTR_LO, lo);
        wr(REG_INSTR_HI, hi);
        @(posedge pclk);
        check({31'h0, export_issue}, 32'h1);
        for (int k = 0; k < 50 && export_hold !== 1'b0; k++) @(posedge pclk);
    endtask
    // Expected destination after an operation.
    function automatic logic [31:0] model(input logic [5:0] op, input logic [31:0] d,
                                          input logic [31:0] s, input logic [31:0] c);
        case ((op >= 6'h24) ? op - 6'h20 : op)
            6'h01, 6'h14, 6'h22: return s;
            6'h04: return (c == d) ? s : d;
            6'h07: return d + s;
            6'h08: return d - s;
            6'h09: return s - d;
            6'h0A: return ($signed(s) < $signed(d)) ? s : d;
            6'h0B: return (s < d) ? s : d;
            6'h0C: return ($signed(s) > $signed(d)) ? s : d;
            6'h0D: return (s > d) ? s : d;
            6'h0E: return d & s;
            6'h0F: return d | s;
            6'h10: return d ^ s;
            6'h12: return (d >= s) ? 32'h0 : d + 32'h1;
            6'h13: return (d == 32'h0 || d > s) ? s : d - 32'h1;
            6'h15: return {d[31:16], s[15:0]};
            6'h16: return {d[31:8], s[7:0]};
            default: return d;
        endcase
    endfunction
    task automatic conclude();
        $display("Checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        conclude();
    end
    initial begin
        logic [31:0] r, d, c;
        logic        e;
        presetn = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int p = 0; p < 2; p++) begin
            for (int op = 0; op < 52; op++) begin
                d = (p == 0) ? 32'h8000_0005 : 32'h0000_0005;
                c = (p == 0) ? d : 32'h0;
                wr(REG_DEST, d);
                wr(REG_SRC, 32'h7);
                wr(REG_CMP, c);
                run(apb_u.lo_word(op[5:0], 4'h0, 2'h0), apb_u.hi_word(FLOW_SCRATCH, 1'b0));
                rd(REG_DEST, r);
                check(r, model(op[5:0], d, 32'h7, c));
                if (op >= 32 && !(op inside {33, 35, 37, 38, 49})) begin
                    rd(REG_RETURN, r);
                    check(r, d);
                end
            end
        end
        $display("Test opcode sweep done");
        wr(REG_INDEX0, 32'h3);
        run(apb_u.lo_word(6'h07, 4'h5, 2'h1), apb_u.hi_word(8'h46, 1'b0));
        rd(REG_DEC0, r);
        check(r, 32'h0000_F1C8);
        rd(REG_DEC2, r);
        check(r, 32'h0000_2016);
        apb_u.xfer(1'b0, 8'h40, 32'h0, r, e);
        check({31'h0, e}, 32'h1);
        $display("Test decode fields done");
        wr(REG_INSTR_LO, apb_u.lo_word(6'h07, 4'h0, 2'h0));
        wr(REG_INSTR_HI, apb_u.hi_word(FLOW_SCRATCH, 1'b1));
        repeat (4) @(posedge pclk);
        check({31'h0, export_hold}, 32'h1);
        wr(REG_INSTR_LO, 32'h0);
        rd(REG_INSTR_LO, r);
        check(r, apb_u.lo_word(6'h07, 4'h0, 2'h0));
        repeat (16) wr(REG_DONE, 32'h0);
        repeat (3) @(posedge pclk);
        check({31'h0, export_hold}, 32'h0);
        wr(REG_THREAD, 32'h0);
        wr(REG_DEST, 32'h9);
        run(apb_u.lo_word(6'h07, 4'h0, 2'h0), apb_u.hi_word(FLOW_SCRATCH, 1'b0));
        rd(REG_DEST, r);
        check(r, 32'h9);
        $display("Test barrier and inactive done");
        conclude();
    end
endmodule

// *** test/uaved_seq_model.sv ***
// Sequencer model: builds instruction words and runs bus transfers.
`timescale 1ns/10ps
module uaved_seq_model (
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata
);
    // Idle bus at time zero.
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    // One transfer; released lines show the inverse of their last value.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
        paddr <= ~a;
        pwdata <= ~d;
        @(posedge pclk);
    endtask
    function automatic logic [31:0] lo_word(input logic [5:0] op, input logic [3:0] v,
                                            input logic [1:0] m);
        return {2'h0, 7'h00, 1'b0, 7'h00, 2'h0, m, 1'b0, op, v};
    endfunction
    function automatic logic [31:0] hi_word(input logic [7:0] f, input logic b);
        return {b, 1'b0, f, 2'h0, 4'h0, 4'hF, 12'h000};
    endfunction
endmodule
